// ===== rtl/dac_door_access.sv
// Door access decision: card lookup, schedules, relays, audit logs, APB registers
//
// Functional notes
// - Search card list per read; grant only if found and it has schedule 0 (none) or its schedule allows now.
// - Grant energises that door's relay for the programmed unlock time.
// - Anti-tailgating on: door closing releases relay at once.
// - Request-to-exit fires relay for unlock time, stand-alone or online.
// - Each granted read appends card number with date and time.
// - Option also logs denied reads.
// - Separate audit log per reader, never mixed.
// - Audit records survive power loss in non-volatile store; here plain registers that only outlast reset.
// - Audit enable bit; when off nothing is logged.
// - Log is circular; when full, oldest record is overwritten.
// - Host may read audit data any time while access continues.
// - Decisions need no host; host writes still change cards and schedules.
// - 199 schedules, each with seven weekday entries.
// - Holiday entry stored as day 7, used during holiday periods.
// - Entry has start and end; end minute is inclusive.
// - Linked schedules: allowed if any schedule in the chain allows.
// - Locally enrolled cards carry no schedule and always pass.
// - Card memory pre-allocated; record size sets card capacity.
// - Real-time clock and schedule time refresh once per second.
`timescale 1ns/1ps
module dac_door_access #(
  parameter int MS_CYCLES = dac_pkg::MS_CYC,
  parameter int POOL = 1024,
  parameter int LOG_DEPTH = 256
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Card readers
  input wire dac_pkg::dac_read_type [1:0] rd_in,
  output logic [1:0] rd_ready,
  // Door pins
  input wire logic [1:0] rex_in,
  input wire logic [1:0] door_position_input,
  output logic [1:0] relay
);
  localparam int PAW = $clog2(POOL);
  localparam int LAW = $clog2(LOG_DEPTH);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [6:0] ctrl;
    logic [15:0] unlock;
    logic [PAW-1:0] card_addr;
    logic [10:0] sched_addr;
    logic [LAW:0] aud_sel;
    dac_pkg::dac_stamp_type now;
    logic [11:0] hhmm;
    logic [31:0] cyc;
    logic [9:0] ms;
    logic [1:0] rex_s1, rex_s2, rex_s3, rex_f;
    logic [1:0] dp_s1, dp_s2, dp_s3, dp_f;
    logic [1:0] relay;
    logic [1:0][15:0] tmr;
    logic [1:0] opened;
    logic [1:0] rdy;
    logic [1:0] pend;
    logic [1:0][dac_pkg::CARD_W-1:0] pcard;
    dac_pkg::dac_eng_type st;
    logic rdr;
    logic [dac_pkg::CARD_W-1:0] card;
    logic [PAW-1:0] idx;
    logic [7:0] cur;
    logic [7:0] steps;
    logic grant;
    logic [PAW-1:0] enr_ptr;
  } dac_state_type;

  dac_state_type q, d;

  // ----------------------------------------
  // Memories
  // ----------------------------------------
  logic [31:0] card_mem [0:POOL-1];
  dac_pkg::dac_sent_type sched_ent [0:dac_pkg::SCHED_N][0:dac_pkg::DAYS-1];
  logic [7:0] sched_link [0:dac_pkg::SCHED_N];
  dac_pkg::dac_rec_type aud_mem [0:1][0:LOG_DEPTH-1];
  logic [LAW-1:0] aud_head [0:1];
  logic [LAW:0] aud_cnt [0:1];

  logic [31:0] rdata;
  logic wr, hit, ms_tick, sec_tick, time_wr, match, long_rec, c_ew, aud_we;
  logic [31:0] lo_w, hi_w;
  logic [PAW-1:0] step;
  logic [2:0] day;
  logic [7:0] nsched;
  logic [1:0] gnt, trig;
  logic [LAW-1:0] aud_addr;
  dac_pkg::dac_rec_type arec, aud_rec;
  dac_pkg::dac_sent_type ent;

  wire logic c_hw = wr && paddr == dac_pkg::A_CARD_DATA;
  wire logic [7:0] s_idx = q.sched_addr[10:3];
  wire logic s_ok = s_idx != 8'h00 && s_idx <= 8'(dac_pkg::SCHED_N);
  wire logic s_hw = wr && paddr == dac_pkg::A_SCHED_DATA && s_ok;
  wire logic l_hw = wr && paddr == dac_pkg::A_SCHED_LINK && s_ok;
  wire logic aud_clr = wr && paddr == dac_pkg::A_CTRL && pwdata[dac_pkg::C_CLR];

  function automatic logic [11:0] hhmm_of(dac_pkg::dac_stamp_type s);
    hhmm_of = {7'h00, s.hour} * dac_pkg::HH_MUL + {6'h00, s.min};
  endfunction

  function automatic logic [31:0] time_of(dac_pkg::dac_stamp_type s);
    time_of = {5'h00, s.wday, 3'h0, s.hour, 2'h0, s.min, 2'h0, s.sec};
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    gnt = 2'b00;
    trig = 2'b00;
    c_ew = 1'b0;
    aud_we = 1'b0;
    match = 1'b0;
    nsched = 8'h00;
    long_rec = q.ctrl[dac_pkg::C_LONG];
    step = long_rec ? PAW'(2) : PAW'(1);
    wr = psel && penable && q.pready && pwrite;
    hit = paddr[1:0] == 2'b00 && paddr <= dac_pkg::A_AUD_CNT;
    time_wr = wr && paddr == dac_pkg::A_TIME;
    day = q.ctrl[dac_pkg::C_HOLIDAY] ? dac_pkg::HOLIDAY_DAY : q.now.wday;
    aud_addr = aud_head[q.aud_sel[LAW]] - aud_cnt[q.aud_sel[LAW]][LAW-1:0]
               + q.aud_sel[LAW-1:0];
    arec = aud_mem[q.aud_sel[LAW]][aud_addr];
    aud_rec = '{grant: q.grant, stamp: q.now, card: q.card};
    lo_w = card_mem[q.idx];
    hi_w = card_mem[q.idx | PAW'(1)];
    ent = sched_ent[q.cur][day];

    // ----------------------------------------
    // Register read and write
    // ----------------------------------------
    unique case (paddr)
      dac_pkg::A_CTRL: rdata = {25'h000_0000, q.ctrl};
      dac_pkg::A_UNLOCK: rdata = {16'h0000, q.unlock};
      dac_pkg::A_TIME: rdata = time_of(q.now);
      dac_pkg::A_DATE: rdata = {16'h0000, q.now.day};
      dac_pkg::A_CARD_ADDR: rdata = 32'(q.card_addr);
      dac_pkg::A_CARD_DATA: rdata = card_mem[q.card_addr];
      dac_pkg::A_SCHED_ADDR: rdata = {21'h00_0000, q.sched_addr};
      dac_pkg::A_SCHED_DATA: rdata = s_ok ? 32'(sched_ent[s_idx][q.sched_addr[2:0]]) : 32'h0000_0000;
      dac_pkg::A_SCHED_LINK: rdata = s_ok ? {24'h00_0000, sched_link[s_idx]} : 32'h0000_0000;
      dac_pkg::A_AUD_SEL: rdata = (32'(q.aud_sel[LAW]) << dac_pkg::AUD_RDR_BIT)
                                  | 32'(q.aud_sel[LAW-1:0]);
      dac_pkg::A_AUD_LO: rdata = arec.card[31:0];
      dac_pkg::A_AUD_HI: rdata = {arec.grant, 1'b0, arec.stamp.day, arec.card[45:32]};
      dac_pkg::A_AUD_TIME: rdata = time_of(arec.stamp);
      dac_pkg::A_STATUS: rdata = {long_rec ? 16'(POOL / 2) : 16'(POOL), 12'h000,
                                  q.grant, q.st != dac_pkg::E_IDLE, q.relay};
      dac_pkg::A_AUD_CNT: rdata = {16'(aud_cnt[1]), 16'(aud_cnt[0])};
      default: rdata = 32'h0000_0000;
    endcase
    d.pready = psel && !penable;
    d.pslverr = psel && !penable && !hit;
    d.prdata = (psel && !penable && !pwrite && hit) ? rdata : 32'h0000_0000;

    // ----------------------------------------
    // Real-time clock
    // ----------------------------------------
    ms_tick = q.cyc == 32'(MS_CYCLES - 1);
    sec_tick = ms_tick && q.ms == 10'(dac_pkg::SEC_MS - 1);
    d.cyc = ms_tick ? 32'h0000_0000 : q.cyc + 32'h0000_0001;
    if (ms_tick) begin
      d.ms = sec_tick ? 10'h000 : q.ms + 10'h001;
    end
    if (sec_tick) begin
      if (q.now.sec != dac_pkg::MAX_SEC) begin
        d.now.sec = q.now.sec + 6'h01;
      end else begin
        d.now.sec = 6'h00;
        if (q.now.min != dac_pkg::MAX_MIN) begin
          d.now.min = q.now.min + 6'h01;
        end else begin
          d.now.min = 6'h00;
          if (q.now.hour != dac_pkg::MAX_HOUR) begin
            d.now.hour = q.now.hour + 5'h01;
          end else begin
            d.now.hour = 5'h00;
            d.now.day = q.now.day + 16'h0001;
            d.now.wday = (q.now.wday == dac_pkg::MAX_WDAY) ? 3'h0 : q.now.wday + 3'h1;
          end
        end
      end
    end

    if (wr) begin
      unique case (paddr)
        dac_pkg::A_CTRL: d.ctrl = pwdata[6:0];
        dac_pkg::A_UNLOCK: d.unlock = pwdata[15:0];
        dac_pkg::A_TIME: begin
          d.now.wday = pwdata[26:24];
          d.now.hour = pwdata[20:16];
          d.now.min = pwdata[13:8];
          d.now.sec = pwdata[5:0];
        end
        dac_pkg::A_DATE: d.now.day = pwdata[15:0];
        dac_pkg::A_CARD_ADDR: d.card_addr = pwdata[PAW-1:0];
        dac_pkg::A_SCHED_ADDR: d.sched_addr = pwdata[10:0];
        dac_pkg::A_AUD_SEL: d.aud_sel = {pwdata[dac_pkg::AUD_RDR_BIT], pwdata[LAW-1:0]};
        default: ;
      endcase
    end
    // Minute-resolution time, frozen between second ticks and time writes
    if (sec_tick || time_wr) begin
      d.hhmm = hhmm_of(d.now);
    end

    // ----------------------------------------
    // Reader capture
    // ----------------------------------------
    for (int i = 0; i < 2; i++) begin
      if (rd_in[i].valid && q.rdy[i]) begin
        d.pend[i] = 1'b1;
        d.pcard[i] = rd_in[i].card;
      end
    end

    // ----------------------------------------
    // Decision engine, runs with no host involvement
    // ----------------------------------------
    unique case (q.st)
      dac_pkg::E_IDLE: begin
        if (q.pend != 2'b00) begin
          d.rdr = !q.pend[0];
          d.card = q.pcard[!q.pend[0]];
          d.idx = '0;
          d.st = q.ctrl[dac_pkg::C_ENROLL] ? dac_pkg::E_ENR : dac_pkg::E_SRCH;
        end
      end
      dac_pkg::E_SRCH: begin
        // One record per cycle; long records take an even/odd word pair
        match = lo_w[dac_pkg::W_VALID] && lo_w[22:0] == q.card[22:0]
                && (long_rec ? hi_w[22:0] == q.card[45:23] : q.card[45:23] == 23'h00_0000);
        nsched = lo_w[30:dac_pkg::W_SCHED];
        if (match) begin
          d.cur = nsched;
          d.steps = 8'h00;
          d.grant = nsched == 8'h00;
          d.st = (nsched == 8'h00 || nsched > 8'(dac_pkg::SCHED_N)) ?
                 dac_pkg::E_FIN : dac_pkg::E_SCHED;
        end else if (q.idx >= PAW'(POOL) - step) begin
          d.grant = 1'b0;
          d.st = dac_pkg::E_FIN;
        end else begin
          d.idx = q.idx + step;
        end
      end
      dac_pkg::E_SCHED: begin
        nsched = sched_link[q.cur];
        if (ent.valid && q.hhmm >= ent.start && q.hhmm <= ent.fin) begin
          d.grant = 1'b1;
          d.st = dac_pkg::E_FIN;
        end else if (nsched == 8'h00 || nsched > 8'(dac_pkg::SCHED_N)
                     || q.steps == 8'(dac_pkg::SCHED_N - 1)) begin
          d.grant = 1'b0;
          d.st = dac_pkg::E_FIN;
        end else begin
          d.cur = nsched;
          d.steps = q.steps + 8'h01;
        end
      end
      dac_pkg::E_FIN: begin
        gnt[q.rdr] = q.grant;
        aud_we = q.ctrl[dac_pkg::C_AUD_EN]
                 && (q.grant || q.ctrl[dac_pkg::C_LOG_DENY]);
        d.pend[q.rdr] = 1'b0;
        d.st = dac_pkg::E_IDLE;
      end
      dac_pkg::E_ENR: begin
        // Host word write has the port this cycle; enrolment waits one
        if (!c_hw) begin
          c_ew = 1'b1;
          d.enr_ptr = q.enr_ptr + step;
          d.pend[q.rdr] = 1'b0;
          d.st = dac_pkg::E_IDLE;
        end
      end
      default: d.st = dac_pkg::E_IDLE;
    endcase
    d.rdy = ~d.pend;

    // ----------------------------------------
    // Pin filters and relays
    // ----------------------------------------
    d.rex_s1 = rex_in;
    d.rex_s2 = q.rex_s1;
    d.rex_s3 = q.rex_s2;
    d.rex_f = (~(q.rex_s2 ^ q.rex_s3) & q.rex_s3) | ((q.rex_s2 ^ q.rex_s3) & q.rex_f);
    d.dp_s1 = door_position_input;
    d.dp_s2 = q.dp_s1;
    d.dp_s3 = q.dp_s2;
    d.dp_f = (~(q.dp_s2 ^ q.dp_s3) & q.dp_s3) | ((q.dp_s2 ^ q.dp_s3) & q.dp_f);
    for (int i = 0; i < 2; i++) begin
      trig[i] = (d.rex_f[i] && !q.rex_f[i]) || gnt[i];
      if (trig[i]) begin
        d.tmr[i] = q.unlock;
        d.relay[i] = q.unlock != 16'h0000;
        d.opened[i] = 1'b0;
      end else if (q.relay[i]) begin
        if (!q.dp_f[i]) begin
          d.opened[i] = 1'b1;
        end
        // Relock only after the door has actually swung open and shut
        if (q.ctrl[dac_pkg::C_ATG0 + i] && q.opened[i] && q.dp_f[i]) begin
          d.relay[i] = 1'b0;
          d.tmr[i] = 16'h0000;
        end else if (ms_tick) begin
          d.tmr[i] = q.tmr[i] - 16'h0001;
          if (q.tmr[i] == 16'h0001) begin
            d.relay[i] = 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl <= dac_pkg::CTRL_RST[6:0];
      q.unlock <= dac_pkg::UNLOCK_RST;
      q.rdy <= 2'b11;
      q.st <= dac_pkg::E_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Card and schedule stores
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (c_hw) begin
      card_mem[q.card_addr] <= pwdata;
    end else if (c_ew) begin
      card_mem[q.enr_ptr] <= {1'b1, 8'h00, q.card[22:0]};
      if (long_rec) begin
        card_mem[q.enr_ptr | PAW'(1)] <= {9'h000, q.card[45:23]};
      end
    end
    if (s_hw) begin
      sched_ent[s_idx][q.sched_addr[2:0]] <= pwdata[24:0];
    end
    if (l_hw) begin
      sched_link[s_idx] <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Audit logs: plain register arrays, untouched by reset
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (aud_clr) begin
      for (int r = 0; r < 2; r++) begin
        aud_head[r] <= '0;
        aud_cnt[r] <= '0;
      end
    end else if (aud_we) begin
      aud_mem[q.rdr][aud_head[q.rdr]] <= aud_rec;
      aud_head[q.rdr] <= aud_head[q.rdr] + LAW'(1);
      if (aud_cnt[q.rdr] != (LAW+1)'(LOG_DEPTH)) begin
        aud_cnt[q.rdr] <= aud_cnt[q.rdr] + (LAW+1)'(1);
      end
    end
  end

  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign rd_ready = q.rdy;
  assign relay = q.relay;
endmodule // dac_door_access

// ===== rtl/dac_pkg.sv
// Constants and carrier types of the door access decision block
package dac_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYC = MS_PS / CLK_PERIOD_PS;
  localparam int SEC_MS = 1000;
  localparam logic [15:0] UNLOCK_RST = 16'h0bb8;
  localparam logic [5:0] MAX_SEC = 6'h3b;
  localparam logic [5:0] MAX_MIN = 6'h3b;
  localparam logic [4:0] MAX_HOUR = 5'h17;
  localparam logic [2:0] MAX_WDAY = 3'h6;

  // ----------------------------------------
  // Schedules and cards
  // ----------------------------------------
  localparam int SCHED_N = 199;
  localparam int DAYS = 8;
  localparam logic [2:0] HOLIDAY_DAY = 3'h7;
  localparam logic [11:0] HH_MUL = 12'h064;
  localparam int CARD_W = 46;
  localparam int LO_W = 23;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_UNLOCK = 8'h04;
  localparam logic [7:0] A_TIME = 8'h08;
  localparam logic [7:0] A_DATE = 8'h0c;
  localparam logic [7:0] A_CARD_ADDR = 8'h10;
  localparam logic [7:0] A_CARD_DATA = 8'h14;
  localparam logic [7:0] A_SCHED_ADDR = 8'h18;
  localparam logic [7:0] A_SCHED_DATA = 8'h1c;
  localparam logic [7:0] A_SCHED_LINK = 8'h20;
  localparam logic [7:0] A_AUD_SEL = 8'h24;
  localparam logic [7:0] A_AUD_LO = 8'h28;
  localparam logic [7:0] A_AUD_HI = 8'h2c;
  localparam logic [7:0] A_AUD_TIME = 8'h30;
  localparam logic [7:0] A_STATUS = 8'h34;
  localparam logic [7:0] A_AUD_CNT = 8'h38;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int C_AUD_EN = 0;
  localparam int C_LOG_DENY = 1;
  localparam int C_ATG0 = 2;
  localparam int C_HOLIDAY = 4;
  localparam int C_LONG = 5;
  localparam int C_ENROLL = 6;
  localparam int C_CLR = 7;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam int AUD_RDR_BIT = 16;
  localparam int W_VALID = 31;
  localparam int W_SCHED = 23;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [CARD_W-1:0] card;
  } dac_read_type;

  typedef struct packed {
    logic valid;
    logic [11:0] start;
    logic [11:0] fin;
  } dac_sent_type;

  typedef struct packed {
    logic [15:0] day;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } dac_stamp_type;

  typedef struct packed {
    logic grant;
    dac_stamp_type stamp;
    logic [CARD_W-1:0] card;
  } dac_rec_type;

  typedef enum logic [2:0] {E_IDLE, E_SRCH, E_SCHED, E_FIN, E_ENR} dac_eng_type;
endpackage

// ===== test/dac_door_access_props.sv
// Port-level assertions for the door access decision block
`timescale 1ns/1ps
module dac_door_access_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Readers and doors
  input wire dac_pkg::dac_read_type [1:0] rd_in,
  input wire logic [1:0] rd_ready,
  input wire logic [1:0] rex_in,
  input wire logic [1:0] door_position_input,
  input wire logic [1:0] relay
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Host access
  // ----------------------------------------
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_apb_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_apb_unmapped: assert property (psel && !penable && (paddr > 8'h38 || paddr[1:0] != 2'b00)
    |=> pready && pslverr) else $error("unmapped access not refused");
  a_err_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without pready or with data");
  a_idle_data: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  // ----------------------------------------
  // Readers and relays
  // ----------------------------------------
  a_slot_taken: assert property (rd_in[0].valid && rd_ready[0] |=> !rd_ready[0])
    else $error("card read not taken");
  a_slot_freed: assert property ($fell(rd_ready[0]) |-> ##[2:400] rd_ready[0])
    else $error("decision never finished");
  a_relay_hold: assert property ($rose(relay[0]) |-> relay[0] [*4])
    else $error("relay pulse too short");
  a_relay_cause: assert property ($rose(relay[1]) |-> !$past(rd_ready[1]) || rex_in[1])
    else $error("relay fired without cause");
  a_exit_fires: assert property ($rose(rex_in[1]) |-> ##[1:8] relay[1])
    else $error("exit request ignored");
  c_grant0: cover property ($rose(relay[0]));
  c_grant1: cover property ($rose(relay[1]) && !rex_in[1]);
  c_refused: cover property (pslverr);
endmodule // dac_door_access_props

bind dac_door_access dac_door_access_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .rd_in(rd_in), .rd_ready(rd_ready), .rex_in(rex_in),
  .door_position_input(door_position_input), .relay(relay));

// ===== test/dac_reader_model.sv
// Pair of card readers presenting one card read per request
`timescale 1ns/1ps
module dac_reader_model (
  // Clock
  input wire logic pclk,
  // Reader slots
  input wire logic [1:0] rd_ready,
  output dac_pkg::dac_read_type [1:0] rd_in
);
  initial rd_in = '0;
  // Strobe only into an empty slot; released card lines are scrambled
  task automatic swipe(input int p, input logic [45:0] c);
    while (rd_ready[p] !== 1'b1) @(posedge pclk);
    rd_in[p].valid <= 1'b1;
    rd_in[p].card <= c;
    @(posedge pclk);
    rd_in[p].valid <= 1'b0;
    rd_in[p].card <= ~c;
  endtask
endmodule // dac_reader_model

// ===== test/dac_door_access_tb_top.sv
// Self-checking bench for the door access decision block
`timescale 1ns/1ps
module dac_door_access_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, ctrl;
  logic [31:0] pwdata, prdata;
  dac_pkg::dac_read_type [1:0] rd_in;
  logic [1:0] rd_ready, rex_in, door_position_input, relay;
  logic [32:0] lq[2][$];
  int failures, cmp_count, cyc;
  // ----------------------------------------
  // Memory image and schedule cases
  // ----------------------------------------
  localparam logic [7:0] IA[25] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h10, 8'h14, 8'h10, 8'h14,
    8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h18, 8'h1c, 8'h18, 8'h1c, 8'h20, 8'h18, 8'h1c,
    8'h18, 8'h1c, 8'h20, 8'h18, 8'h1c};
  localparam logic [31:0] ID[25] = '{32'h81, 32'h5, 32'h0, 32'h8000_0011, 32'h1,
    32'h8080_0022, 32'h2, 32'h8100_0033, 32'h3, 32'h0, 32'h9, 32'h012b_c5f9, 32'h0, 32'hf,
    32'h0100_0064, 32'h11, 32'h012b_c487, 32'h3, 32'h17, 32'h0, 32'h19, 32'h0151_4640,
    32'h0, 32'h1f, 32'h0};
  localparam logic [7:0] TC[8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h13, 8'h13};
  localparam logic [31:0] TT[8] = '{32'h010f_1d00, 32'h010f_1e00, 32'h010f_1e00,
    32'h010b_0000, 32'h010c_1e00, 32'h010d_0a00, 32'h010f_1d00, 32'h0100_1e00};
  localparam logic [7:0] TK[8] = '{8'h22, 8'h22, 8'h44, 8'h33, 8'h33, 8'h33, 8'h22, 8'h22};
  localparam logic [7:0] TE = 8'ha9;

  dac_door_access #(.MS_CYCLES(2), .POOL(4), .LOG_DEPTH(4)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .rd_in(rd_in),
    .rd_ready(rd_ready), .rex_in(rex_in), .door_position_input(door_position_input),
    .relay(relay));
  dac_reader_model rdr_u (.pclk(pclk), .rd_ready(rd_ready), .rd_in(rd_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Whole run needs about 2100 cycles; generous ceiling
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test();
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 20), 32'h1);
    if (w && a == 8'h00) ctrl = d[7:0];
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  // Card read, grant seen on relay, pulse length, expected log entry
  task automatic swipe(input int p, input logic [7:0] c, input logic g);
    int n;
    logic got;
    rdr_u.swipe(p, {38'h0, c});
    got = 1'b0;
    for (n = 0; n < 60 && got !== 1'b1; n++) begin
      @(posedge pclk);
      got = relay[p];
    end
    chk({31'h0, got}, {31'h0, g});
    if (got === 1'b1) begin
      for (n = 0; relay[p] === 1'b1 && n < 60; n++) @(posedge pclk);
      chk(32'(n > 16 && n < 23), 32'h1);
    end
    if (ctrl[0] && (g || ctrl[1])) lq[p].push_back({g, 24'h0, c});
    if (lq[p].size() > 4) void'(lq[p].pop_front());
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(8'h00, 32'h0000_0001, 1'b0);
    rd(8'h04, 32'h0000_0bb8, 1'b0);
    rd(8'h3c, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    wr(8'h04, 32'h0000_000a);
    rd(8'h04, 32'h0000_000a, 1'b0);
    rd(8'h34, 32'h0004_0000, 1'b0);
    wr(8'h00, 32'h0000_0021);
    rd(8'h34, 32'h0002_0000, 1'b0);
  endtask
  task automatic t_sched();
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {24'h0, TC[i]});
      wr(8'h08, TT[i]);
      swipe(0, TK[i], TE[i]);
    end
  endtask
  task automatic t_mem();
    wr(8'h00, 32'h0000_0001);
    wr(8'h08, 32'h010f_1d00);
    wr(8'h10, 32'h0000_0001);
    rd(8'h14, 32'h8080_0022, 1'b0);
    wr(8'h14, 32'h0000_0000);
    swipe(0, 8'h22, 1'b0);
  endtask
  task automatic t_any();
    wr(8'h00, 32'h0000_0000);
    swipe(1, 8'h11, 1'b1);
    wr(8'h00, 32'h0000_0001);
    swipe(1, 8'h11, 1'b1);
    fork
      swipe(0, 8'h11, 1'b1);
      swipe(1, 8'h11, 1'b1);
    join
  endtask
  task automatic t_tailgate();
    int n;
    wr(8'h00, 32'h0000_0005);
    rdr_u.swipe(0, 46'h11);
    for (n = 0; n < 60 && relay[0] !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, relay[0]}, 32'h1);
    door_position_input[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    door_position_input[0] <= 1'b1;
    for (n = 0; n < 60 && relay[0] === 1'b1; n++) @(posedge pclk);
    chk(32'(n < 9), 32'h1);
    lq[0].push_back({1'b1, 32'h11});
    if (lq[0].size() > 4) void'(lq[0].pop_front());
    wr(8'h00, 32'h0000_0001);
  endtask
  task automatic t_exit();
    rex_in[1] <= 1'b1;
    repeat (10) @(posedge pclk);
    chk({31'h0, relay[1]}, 32'h1);
    rex_in[1] <= 1'b0;
    repeat (8) @(posedge pclk);
    rex_in[1] <= 1'b1;
    repeat (15) @(posedge pclk);
    chk({31'h0, relay[1]}, 32'h1);
    rex_in[1] <= 1'b0;
    repeat (30) @(posedge pclk);
    chk({31'h0, relay[1]}, 32'h0);
  endtask
  // Enrolled card overwrites word 0 and then passes; host read overlaps a search
  task automatic t_enrol();
    wr(8'h00, 32'h0000_0041);
    swipe(0, 8'h55, 1'b0);
    wr(8'h00, 32'h0000_0001);
    wr(8'h10, 32'h0000_0000);
    rd(8'h14, 32'h8000_0055, 1'b0);
    fork
      swipe(0, 8'h55, 1'b1);
      rd(8'h00, 32'h0000_0001, 1'b0);
    join
  endtask
  // Clock rolls over midnight at the next second tick
  task automatic t_clock();
    logic [31:0] r;
    logic e;
    int n;
    wr(8'h08, 32'h0117_3b3b);
    r = 32'h0117_3b3b;
    for (n = 0; n < 800 && r == 32'h0117_3b3b; n++) apb(8'h08, 1'b0, 32'h0, r, e);
    chk(r, 32'h0200_0000);
    rd(8'h0c, 32'h0000_0006, 1'b0);
  endtask
  // Reset in mid-run first: logs must outlive it
  task automatic t_audit();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h38, {16'(lq[1].size()), 16'(lq[0].size())}, 1'b0);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < lq[p].size(); i++) begin
        wr(8'h24, (32'(p) << 16) | 32'(i));
        rd(8'h28, lq[p][i][31:0], 1'b0);
        rd(8'h2c, {lq[p][i][32], 17'h0_0005, 14'h0}, 1'b0);
      end
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rex_in = 2'b00;
    door_position_input = 2'b11;
    ctrl = 8'h01;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    for (int i = 0; i < 25; i++) wr(IA[i], ID[i]);
    t_sched();
    t_mem();
    t_any();
    t_tailgate();
    t_exit();
    t_enrol();
    t_clock();
    t_audit();
    finish_test();
  end
endmodule // dac_door_access_tb_top
